// ---- src/srd_map.vh ----
// address map, field positions and reset values of the special register space decoder
`ifndef SRD_MAP_VH
`define SRD_MAP_VH
`define SRD_SPACE_LO     8'h80
`define SRD_SPACE_HI     8'hff
`define SRD_SPACE_BIT    7
`define SRD_BITADR_NIB   3'h0
`define SRD_ADDR_DERIV   8'had
`define SRD_ADDR_FAMILY  8'hb5
`define SRD_ADDR_REV     8'hb6
`define SRD_RSV_DATA     8'h00
`define SRD_RST_DATA     8'h00
`endif

// ---- src/srd_bit_decode.v ----
// bit address to register address and bit position decoder
`include "srd_map.vh"
module srd_bit_decode
(
  input  wire [7:0] bit_addr_i,
  output wire       space_hit_o,
  output wire [7:0] reg_addr_o,
  output wire [2:0] bit_pos_o
);
  // upper bit addresses select registers ending in 0x0 or 0x8
  assign space_hit_o = bit_addr_i[`SRD_SPACE_BIT];
  assign reg_addr_o  = {bit_addr_i[7:3], `SRD_BITADR_NIB}; // R3 R4
  assign bit_pos_o   = bit_addr_i[2:0];
endmodule

// ---- src/srd_top.v ----
// special register space decoder with identification bytes
// Operation
// R1: registers occupy direct addresses 0x80 to 0xff
// R2: direct access in upper range selects registers
// R3: addresses ending 0x0 or 0x8 allow bit access
// R4: other addresses are byte-only, never bit-selected
// R5: core must avoid reserved addresses
// R6: read-only revision byte at 0xb6
// R7: read-only family byte at 0xb5
// R8: read-only derivative byte at 0xad
// R9: indirect upper accesses go to upper ram
// R10: id writes ignored, reserved reads zero
`include "srd_map.vh"
module srd_top
#(
  parameter [7:0] HW_REVISION = 8'h5a, // arbitrary value
  parameter [7:0] FAMILY_ID   = 8'h5b, // arbitrary value
  parameter [7:0] DERIV_ID    = 8'h5c  // arbitrary value
)
(
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  input  wire [7:0] addr_i,
  input  wire       direct_i,
  input  wire       bit_op_i,
  input  wire [2:0] bit_pos_i,
  input  wire       rd_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  input  wire [7:0] periph_rdata_i,
  input  wire       periph_ack_i,
  output wire [7:0] rdata_o,
  output wire       rbit_o,
  output wire       rvalid_o,
  output wire       space_sel_o,
  output wire       space_wr_o,
  output wire [7:0] space_addr_o,
  output wire [7:0] space_wdata_o,
  output wire [7:0] space_wmask_o,
  output wire       uram_sel_o,
  output wire       reserved_o
);
  ////////////////////////////////////////////////////////////////
  // address decode
  wire       bhit;
  wire [7:0] baddr;
  wire [2:0] bpos;
  srd_bit_decode u_bit
  (
    .bit_addr_i  (addr_i),
    .space_hit_o (bhit),
    .reg_addr_o  (baddr),
    .bit_pos_o   (bpos)
  );
  wire       upper   = (addr_i >= `SRD_SPACE_LO); // R1
  wire       req     = rd_i | wr_i;
  wire       byte_sp = direct_i & ~bit_op_i & upper; // R2
  wire       bit_sp  = direct_i & bit_op_i & bhit; // R3 R4
  wire       sp_hit  = byte_sp | bit_sp;
  wire [7:0] eaddr   = bit_op_i ? baddr : addr_i;
  wire [2:0] epos    = bit_op_i ? bpos : bit_pos_i;
  wire       uram    = ~direct_i & upper; // R9
  reg        id_hit;
  reg  [7:0] id_val;
  always @*
  begin
    id_hit = 1'b1;
    if (eaddr == `SRD_ADDR_REV)
      id_val = HW_REVISION; // R6
    else if (eaddr == `SRD_ADDR_FAMILY)
      id_val = FAMILY_ID; // R7
    else if (eaddr == `SRD_ADDR_DERIV)
      id_val = DERIV_ID; // R8
    else
    begin
      id_hit = 1'b0;
      id_val = `SRD_RSV_DATA;
    end
  end
  wire       rsv   = ~id_hit & ~periph_ack_i; // R5
  wire [7:0] rbyte = id_hit ? id_val : (periph_ack_i ? periph_rdata_i : `SRD_RSV_DATA); // R10
  // one-hot lane for bit ops, all lanes for byte ops
  wire [7:0] mask  = bit_op_i ? (8'h01 << epos) : 8'hff; // R3 R4
  wire       rd_hit = rd_i & sp_hit;

  ////////////////////////////////////////////////////////////////
  // next values of the answer
  reg  [7:0] rdata_d;
  reg        rbit_d;
  reg        rvalid_d;
  reg        sel_d;
  reg        wr_d;
  reg  [7:0] addr_d;
  reg  [7:0] wdata_d;
  reg  [7:0] wmask_d;
  reg        uram_d;
  reg        rsv_d;
  always @*
  begin
    sel_d    = req & sp_hit; // R2
    // id bytes are read-only, so no write strobe for them
    wr_d     = wr_i & sp_hit & ~id_hit; // R10
    addr_d   = eaddr;
    // bit ops replicate the bit and keep only its lane
    wdata_d  = bit_op_i ? ({8{wdata_i[0]}} & mask) : wdata_i; // R3
    wmask_d  = mask;
    uram_d   = req & uram; // R9
    rsv_d    = req & sp_hit & rsv;
    rvalid_d = rd_hit;
    // reserved places read as zero
    rdata_d  = rd_hit ? rbyte : `SRD_RSV_DATA; // R10
    rbit_d   = rd_hit ? rbyte[epos] : 1'b0; // R3
  end

  ////////////////////////////////////////////////////////////////
  // registered answer
  reg  [7:0] rdata_q;
  reg        rbit_q;
  reg        rvalid_q;
  reg        sel_q;
  reg        wr_q;
  reg  [7:0] addr_q;
  reg  [7:0] wdata_q;
  reg  [7:0] wmask_q;
  reg        uram_q;
  reg        rsv_q;
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q  <= `SRD_RST_DATA;
      rbit_q   <= 1'b0;
      rvalid_q <= 1'b0;
      sel_q    <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= `SRD_RST_DATA;
      wdata_q  <= `SRD_RST_DATA;
      wmask_q  <= `SRD_RST_DATA;
      uram_q   <= 1'b0;
      rsv_q    <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rbit_q   <= rbit_d;
      rvalid_q <= rvalid_d;
      sel_q    <= sel_d;
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      wmask_q  <= wmask_d;
      uram_q   <= uram_d;
      rsv_q    <= rsv_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs straight from the flip-flops
  assign rdata_o       = rdata_q;
  assign rbit_o        = rbit_q;
  assign rvalid_o      = rvalid_q;
  assign space_sel_o   = sel_q;
  assign space_wr_o    = wr_q;
  assign space_addr_o  = addr_q;
  assign space_wdata_o = wdata_q;
  assign space_wmask_o = wmask_q;
  assign uram_sel_o    = uram_q;
  assign reserved_o    = rsv_q;
endmodule

// ---- testbench/srd_top_asserts.sv ----
// checker for the decoder
module srd_chk #(parameter logic [7:0] HW_REVISION=8'h5a,FAMILY_ID=8'h5b,DERIV_ID=8'h5c)
(input logic sys_clk_i,rst_n_i,direct_i,bit_op_i,rd_i,wr_i,periph_ack_i,space_sel_o,
 space_wr_o,rvalid_o,uram_sel_o,reserved_o,
 input logic [7:0] addr_i,rdata_o,space_addr_o,space_wmask_o);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_by(r); r && direct_i && !bit_op_i; endsequence
  sequence s_id; addr_i inside {8'had,8'hb5,8'hb6}; endsequence
  a_dir_space: assert property (s_by(rd_i|wr_i) ##0 addr_i[7] |=> space_sel_o &&
    space_addr_o==$past(addr_i)) else $error("space miss");
  a_low_none: assert property ((rd_i|wr_i) && !addr_i[7] |=> !space_sel_o && !uram_sel_o)
    else $error("low hit");
  a_ind_uram: assert property ((rd_i|wr_i) && !direct_i && !bit_op_i && addr_i[7]
    |=> uram_sel_o && !space_sel_o) else $error("uram miss");
  a_bit_lane: assert property (wr_i && bit_op_i && direct_i && addr_i[7] |=>
    space_addr_o[2:0]==0 && space_wmask_o==8'h1<<$past(addr_i[2:0])) else $error("bit lane");
  a_rev_rd: assert property (s_by(rd_i) ##0 addr_i==8'hb6 |=> rvalid_o && rdata_o==HW_REVISION)
    else $error("rev");
  a_fam_rd: assert property (s_by(rd_i) ##0 addr_i==8'hb5 |=> rdata_o==FAMILY_ID) else $error("fam");
  a_der_rd: assert property (s_by(rd_i) ##0 addr_i==8'had |=> rdata_o==DERIV_ID) else $error("der");
  a_id_wr: assert property (s_by(wr_i) ##0 s_id |=> space_sel_o && !space_wr_o)
    else $error("id wr");
  a_rsv_zero: assert property (s_by(rd_i) ##0 addr_i[7] && !periph_ack_i && !(addr_i inside
    {8'had,8'hb5,8'hb6}) |=> reserved_o && rdata_o==0) else $error("rsv");
endmodule
bind srd_top srd_chk #(.HW_REVISION(HW_REVISION),.FAMILY_ID(FAMILY_ID),.DERIV_ID(DERIV_ID)) u_chk(.*);

// ---- testbench/srd_periph_model.sv ----
// peripheral responder at occupied places
module srd_periph_model (input logic [7:0] addr_i, input logic bit_op_i, output logic ack_o,
  output logic [7:0] data_o);
  // peripherals answer at the effective register address
  logic [7:0] ea;
  assign ea = bit_op_i ? {addr_i[7:3], 3'h0} : addr_i;
  assign ack_o = ea[7] && ea[3:0]==4'h0;
  assign data_o = ack_o ? ~ea : 8'h3c ^ ea;
endmodule

// ---- testbench/tb_srd_top.sv ----
// testbench for the decoder
module tb_srd_top;
  timeunit 1ns; timeprecision 1ps;
  logic sys_clk_i=0,rst_n_i=0,direct_i=0,bit_op_i=0,rd_i=0,wr_i=0,periph_ack_i,rbit_o,rvalid_o;
  logic space_sel_o,space_wr_o,uram_sel_o,reserved_o;
  logic [2:0] bit_pos_i=0;
  logic [10:0] v;
  logic [7:0] addr_i=0,wdata_i=0,periph_rdata_i,rdata_o,space_addr_o,space_wdata_o,space_wmask_o;
  integer errors=0,comparisons=0,seed=32'h9cbacbe9,i;
  srd_top dut_u (.*);
  srd_periph_model per_u (.addr_i(addr_i),.bit_op_i(bit_op_i),.ack_o(periph_ack_i),
    .data_o(periph_rdata_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  function logic [7:0] ex(input logic [7:0] a);
    case (a) 8'had: ex=8'h5c; 8'hb5: ex=8'h5b; 8'hb6: ex=8'h5a; default: ex=a[3:0]==0 ? ~a : 8'h00; endcase
  endfunction
  function logic isid(input logic [7:0] a);
    isid = a==8'had || a==8'hb5 || a==8'hb6;
  endfunction
  task chk(input string n, input logic [7:0] e, s);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task go(input logic [7:0] a, input logic r, d, b);
    logic [7:0] ea, e, w;
    logic [2:0] eb;
    logic       hit;
    @(posedge sys_clk_i);
    w = 8'($random(seed));
    eb = 3'($random(seed));
    addr_i<=a; rd_i<=r; wr_i<=!r; direct_i<=d; bit_op_i<=b; wdata_i<=w; bit_pos_i<=eb;
    ea = b ? {a[7:3],3'h0} : a;
    if (b) eb = a[2:0];
    hit = d && a[7];
    e = ex(ea);
    @(posedge sys_clk_i);
    rd_i<=0; wr_i<=0;
    #1;
    chk("space_sel_o", 8'(hit), 8'(space_sel_o));
    chk("uram_sel_o", 8'(!d && a[7]), 8'(uram_sel_o));
    chk("rvalid_o", 8'(r && hit), 8'(rvalid_o));
    chk("rdata_o", (r && hit) ? e : 8'h00, rdata_o);
    chk("rbit_o", 8'((r && hit) ? e[eb] : 1'b0), 8'(rbit_o));
    chk("reserved_o", 8'(hit && !isid(ea) && ea[3:0]!=0), 8'(reserved_o));
    chk("space_wr_o", 8'(!r && hit && !isid(ea)), 8'(space_wr_o));
    if (hit)
    begin
      chk("space_addr_o", ea, space_addr_o);
      chk("space_wmask_o", b ? 8'h01 << eb : 8'hff, space_wmask_o);
      if (!r) chk("space_wdata_o", b ? {8{w[0]}} & (8'h01 << eb) : w, space_wdata_o);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1;
    go(8'hb6,1,1,0);
    go(8'hb5,1,1,0);
    go(8'had,1,1,0);
    go(8'hb6,0,1,0);
    go(8'hb4,1,1,0);
    go(8'h8b,0,1,1);
    go(8'h8b,1,1,1);
    go(8'h93,1,1,1);
    go(8'hb6,1,0,0);
    go(8'h20,1,1,1);
    $display("corner test done");
    for (i = 0; i < 400; i++)
    begin
      v = 11'($random(seed));
      go(v[7:0],v[8],v[9],v[10]);
    end
    $display("random test done");
    give_verdict;
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    errors++;
    give_verdict;
  end
endmodule
